// >>> logic/aifs_pkg.sv
// shared constants for the analog input fault and status block
`default_nettype none

package aifs_pkg;

   // channel and word geometry
   localparam int NUM_CH = 8;
   localparam int WORD_W = 16;
   localparam int STAT_W = 8;
   localparam int ALARM_W = 5;
   localparam int KIND_W = 2;

   // module_fault_summary bit positions (11..14 carry nothing)
   localparam int SUM_GROUP_BIT = 15;
   localparam int SUM_CAL_BUSY_BIT = 10;
   localparam int SUM_CAL_ERR_BIT = 9;

   // channel_status_flags bit positions
   localparam int STAT_CAL_ERR_BIT = 7;
   localparam int STAT_BELOW_BIT = 6;
   localparam int STAT_ABOVE_BIT = 5;
   localparam int STAT_ALARM_LSB = 0;
   // alarm input order inside the five alarm bits, lsb first
   localparam int ALM_HIGH_HIGH = 0;
   localparam int ALM_LOW_LOW = 1;
   localparam int ALM_HIGH = 2;
   localparam int ALM_LOW = 3;
   localparam int ALM_SLOPE = 4;

   // wiring mode codes; the spare code behaves as single-ended
   localparam logic [1:0] WIRE_SINGLE = 2'h0;
   localparam logic [1:0] WIRE_DIFF = 2'h1;
   localparam logic [1:0] WIRE_HSDIFF = 2'h2;

   // active-channel masks, also the fault word shown while calibrating
   localparam logic [WORD_W-1:0] MASK_SINGLE = 16'h00FF;
   localparam logic [WORD_W-1:0] MASK_DIFF = 16'h000F;
   localparam logic [WORD_W-1:0] MASK_HSDIFF = 16'h0003;
   localparam logic [WORD_W-1:0] FAULT_ALL = 16'hFFFF;

   // active channel counts per wiring mode
   localparam logic [3:0] COUNT_SINGLE = 4'h8;
   localparam logic [3:0] COUNT_DIFF = 4'h4;
   localparam logic [3:0] COUNT_HSDIFF = 4'h2;

   // communication method: all channel status words, or active ones only
   localparam logic COMM_ALL_CHANNELS = 1'b1;

   // tag carried with each transmitted word
   localparam logic [KIND_W-1:0] KIND_SUMMARY = 2'h0;
   localparam logic [KIND_W-1:0] KIND_FAULTS = 2'h1;
   localparam logic [KIND_W-1:0] KIND_DATA = 2'h2;
   localparam logic [KIND_W-1:0] KIND_STATUS = 2'h3;

   typedef enum logic [2:0] {SEQ_IDLE, SEQ_SUMMARY, SEQ_FAULTS, SEQ_DATA, SEQ_STATUS} aifs_seq_type;

endpackage

`default_nettype wire

// >>> logic/aifs_channel_status.sv
// per-channel status word: range detection and flag assembly
`timescale 1ns/10ps
`default_nettype none

module aifs_channel_status #(
   parameter int DATA_W = 16,
   parameter logic [DATA_W-1:0] DATA_MIN = 16'h0000,
   parameter logic [DATA_W-1:0] DATA_MAX = 16'hFFFF
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // channel conditions
   input wire logic [DATA_W-1:0] sample,
   input wire logic calError,
   input wire logic [aifs_pkg::ALARM_W-1:0] alarms,
   // assembled status
   output logic [aifs_pkg::STAT_W-1:0] statusWord,
   output logic rangeFault
);

   logic belowNow;
   logic aboveNow;
   logic [aifs_pkg::STAT_W-1:0] status_nxt;
   logic [aifs_pkg::STAT_W-1:0] status_r;

   ////////////////////////////////////////////////////////////////////////////////
   // range detection: equality counts as out of range
   assign belowNow = (sample <= DATA_MIN);
   assign aboveNow = (sample >= DATA_MAX);

   always_comb
   begin
      status_nxt = '0;
      status_nxt[aifs_pkg::STAT_CAL_ERR_BIT] = calError;
      status_nxt[aifs_pkg::STAT_BELOW_BIT] = belowNow;
      status_nxt[aifs_pkg::STAT_ABOVE_BIT] = aboveNow;
      status_nxt[aifs_pkg::STAT_ALARM_LSB +: aifs_pkg::ALARM_W] = alarms;
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         status_r <= '0;
      else
         status_r <= status_nxt;
   end

   assign statusWord = status_r;
   // only the two range flags reach the fault word; alarms stay local
   assign rangeFault = status_r[aifs_pkg::STAT_BELOW_BIT] | status_r[aifs_pkg::STAT_ABOVE_BIT];

endmodule

`default_nettype wire

// >>> logic/aifs_fault_status.sv
// fault and status aggregation and multicast word sequencer
//
// Notes on behaviour
// - fault and status words go with every data set
// - summary bit 15 set when fault word nonzero
// - summary bit 10 set while any channel calibrates
// - summary bit 9 set on any calibration error
// - summary bits 11 to 14 read zero
// - one fault bit per active channel, from bit 0
// - range condition sets that channel's fault bit
// - calibrating forces mask pattern by wiring mode
// - lost owner link shows all-ones fault word
// - status bits 7,6,5: cal error, below, above
// - status bits 4..0: slope, low, high, lowlow, highhigh
// - alarm bits never reach fault or summary
// - status word count follows communication method
// - any status bit 7 sets summary bit 9
// - range flags at or beyond detectable limits
`timescale 1ns/10ps
`default_nettype none

module aifs_fault_status #(
   parameter int NUM_CH = aifs_pkg::NUM_CH,
   parameter int DATA_W = 16,
   parameter logic [DATA_W-1:0] DATA_MIN = 16'h0000,
   parameter logic [DATA_W-1:0] DATA_MAX = 16'hFFFF
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // configuration and link state
   input wire logic [1:0] wiringMode,
   input wire logic commMethod,
   input wire logic ownerCommLost,
   // per-channel conditions
   input wire logic [NUM_CH-1:0] chanCalibrating,
   input wire logic [NUM_CH-1:0] chanCalError,
   input wire logic [NUM_CH*aifs_pkg::ALARM_W-1:0] chanAlarms,
   input wire logic [NUM_CH*DATA_W-1:0] chanSample,
   // a new set of channel data is ready to multicast
   input wire logic dataSetReady,
   // live status words
   output logic [aifs_pkg::WORD_W-1:0] moduleFaultSummary,
   output logic [aifs_pkg::WORD_W-1:0] channelFaultBits,
   output logic [NUM_CH*aifs_pkg::STAT_W-1:0] channelStatusFlags,
   // multicast word stream
   output logic txValid,
   output logic txFirst,
   output logic txLast,
   output logic [aifs_pkg::KIND_W-1:0] txKind,
   output logic [3:0] txChannel,
   output logic [aifs_pkg::WORD_W-1:0] txWord,
   output logic txBusy,
   output logic txOverrun
);

   localparam int STAT_W = aifs_pkg::STAT_W;
   localparam int WORD_W = aifs_pkg::WORD_W;
   localparam int ALARM_W = aifs_pkg::ALARM_W;

   logic [NUM_CH*STAT_W-1:0] statusLive;
   logic [NUM_CH-1:0] rangeLive;
   logic [NUM_CH-1:0] calErrLive;
   logic [WORD_W-1:0] rangeWord;
   logic [WORD_W-1:0] activeMask;
   logic [3:0] activeCount;
   logic [3:0] deliverCount;
   logic anyCalibrating;
   logic anyCalError;
   logic [WORD_W-1:0] fault_nxt;
   logic [WORD_W-1:0] summary_nxt;
   logic [WORD_W-1:0] fault_r;
   logic [WORD_W-1:0] summary_r;
   logic [NUM_CH*STAT_W-1:0] statusOut_r;

   ////////////////////////////////////////////////////////////////////////////////
   // per-channel status words
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi = gi + 1)
      begin : gen_ch
         aifs_channel_status #(
            .DATA_W(DATA_W),
            .DATA_MIN(DATA_MIN),
            .DATA_MAX(DATA_MAX)
         ) u_status (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .sample(chanSample[gi*DATA_W +: DATA_W]),
            .calError(chanCalError[gi]),
            .alarms(chanAlarms[gi*ALARM_W +: ALARM_W]),
            .statusWord(statusLive[gi*STAT_W +: STAT_W]),
            .rangeFault(rangeLive[gi])
         );
         assign calErrLive[gi] = statusLive[gi*STAT_W + aifs_pkg::STAT_CAL_ERR_BIT];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // wiring mode decode: mask and count of active channels
   assign activeMask = (wiringMode == aifs_pkg::WIRE_DIFF) ? aifs_pkg::MASK_DIFF :
                       (wiringMode == aifs_pkg::WIRE_HSDIFF) ? aifs_pkg::MASK_HSDIFF :
                       aifs_pkg::MASK_SINGLE;
   assign activeCount = (wiringMode == aifs_pkg::WIRE_DIFF) ? aifs_pkg::COUNT_DIFF :
                        (wiringMode == aifs_pkg::WIRE_HSDIFF) ? aifs_pkg::COUNT_HSDIFF :
                        aifs_pkg::COUNT_SINGLE;
   // status word count depends on how the data is delivered
   assign deliverCount = (commMethod == aifs_pkg::COMM_ALL_CHANNELS) ? 4'(NUM_CH) : activeCount;

   assign rangeWord = WORD_W'(rangeLive);
   assign anyCalibrating = |chanCalibrating;
   assign anyCalError = |calErrLive;

   // link loss outranks calibration, which outranks range faults
   assign fault_nxt = ownerCommLost ? aifs_pkg::FAULT_ALL :
                      anyCalibrating ? activeMask :
                      (rangeWord & activeMask);

   always_comb
   begin
      summary_nxt = '0;
      summary_nxt[aifs_pkg::SUM_GROUP_BIT] = |fault_nxt;
      summary_nxt[aifs_pkg::SUM_CAL_BUSY_BIT] = anyCalibrating;
      summary_nxt[aifs_pkg::SUM_CAL_ERR_BIT] = anyCalError;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fault_r <= '0;
         summary_r <= '0;
         statusOut_r <= '0;
      end
      else
      begin
         fault_r <= fault_nxt;
         summary_r <= summary_nxt;
         statusOut_r <= statusLive;
      end
   end

   assign moduleFaultSummary = summary_r;
   assign channelFaultBits = fault_r;
   assign channelStatusFlags = statusOut_r;

   ////////////////////////////////////////////////////////////////////////////////
   // frame snapshot: data and status frozen when the data set is taken,
   // but status, fault and summary words come from flops two cycles behind the data words
   aifs_pkg::aifs_seq_type seq_r;
   aifs_pkg::aifs_seq_type seq_nxt;
   logic [DATA_W-1:0] dataSnap [NUM_CH];
   logic [STAT_W-1:0] statSnap [NUM_CH];
   logic [WORD_W-1:0] summarySnap_r;
   logic [WORD_W-1:0] faultSnap_r;
   logic [3:0] countSnap_r;
   logic [3:0] chan_r;
   logic [3:0] chan_nxt;
   logic takeFrame;
   logic lastChan;
   logic [WORD_W-1:0] word_nxt;
   logic [aifs_pkg::KIND_W-1:0] kind_nxt;
   logic valid_nxt;
   logic first_nxt;
   logic last_nxt;
   logic txValid_r;
   logic txFirst_r;
   logic txLast_r;
   logic [aifs_pkg::KIND_W-1:0] txKind_r;
   logic [3:0] txChannel_r;
   logic [WORD_W-1:0] txWord_r;
   logic txBusy_r;
   logic txOverrun_r;

   assign takeFrame = dataSetReady && (seq_r == aifs_pkg::SEQ_IDLE);
   assign lastChan = (chan_r == countSnap_r - 4'h1);

   always_ff @(posedge ref_clk)
   begin
      if (takeFrame)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            dataSnap[i] <= chanSample[i*DATA_W +: DATA_W];
            statSnap[i] <= statusOut_r[i*STAT_W +: STAT_W];
         end
      end
   end

   always_comb
   begin
      seq_nxt = seq_r;
      chan_nxt = chan_r;
      valid_nxt = 1'b0;
      first_nxt = 1'b0;
      last_nxt = 1'b0;
      kind_nxt = aifs_pkg::KIND_SUMMARY;
      word_nxt = '0;
      case (seq_r)
         aifs_pkg::SEQ_IDLE:
         begin
            if (dataSetReady)
               seq_nxt = aifs_pkg::SEQ_SUMMARY;
            chan_nxt = '0;
         end
         aifs_pkg::SEQ_SUMMARY:
         begin
            valid_nxt = 1'b1;
            first_nxt = 1'b1;
            kind_nxt = aifs_pkg::KIND_SUMMARY;
            word_nxt = summarySnap_r;
            seq_nxt = aifs_pkg::SEQ_FAULTS;
         end
         aifs_pkg::SEQ_FAULTS:
         begin
            valid_nxt = 1'b1;
            kind_nxt = aifs_pkg::KIND_FAULTS;
            word_nxt = faultSnap_r;
            seq_nxt = aifs_pkg::SEQ_DATA;
         end
         aifs_pkg::SEQ_DATA:
         begin
            valid_nxt = 1'b1;
            kind_nxt = aifs_pkg::KIND_DATA;
            word_nxt = WORD_W'(dataSnap[chan_r[2:0]]);
            seq_nxt = aifs_pkg::SEQ_STATUS;
         end
         aifs_pkg::SEQ_STATUS:
         begin
            valid_nxt = 1'b1;
            kind_nxt = aifs_pkg::KIND_STATUS;
            word_nxt = WORD_W'(statSnap[chan_r[2:0]]);
            if (lastChan)
            begin
               last_nxt = 1'b1;
               seq_nxt = aifs_pkg::SEQ_IDLE;
            end
            else
            begin
               chan_nxt = chan_r + 4'h1;
               seq_nxt = aifs_pkg::SEQ_DATA;
            end
         end
         default:
         begin
            seq_nxt = aifs_pkg::SEQ_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         seq_r <= aifs_pkg::SEQ_IDLE;
         chan_r <= '0;
         summarySnap_r <= '0;
         faultSnap_r <= '0;
         countSnap_r <= aifs_pkg::COUNT_SINGLE;
      end
      else
      begin
         seq_r <= seq_nxt;
         chan_r <= chan_nxt;
         if (takeFrame)
         begin
            summarySnap_r <= summary_r;
            faultSnap_r <= fault_r;
            countSnap_r <= deliverCount;
         end
      end
   end

   // output stage: every stream output straight from a flop
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txValid_r <= 1'b0;
         txFirst_r <= 1'b0;
         txLast_r <= 1'b0;
         txKind_r <= aifs_pkg::KIND_SUMMARY;
         txChannel_r <= '0;
         txWord_r <= '0;
         txBusy_r <= 1'b0;
         txOverrun_r <= 1'b0;
      end
      else
      begin
         txValid_r <= valid_nxt;
         txFirst_r <= first_nxt;
         txLast_r <= last_nxt;
         txKind_r <= kind_nxt;
         txChannel_r <= chan_r;
         txWord_r <= word_nxt;
         txBusy_r <= (seq_nxt != aifs_pkg::SEQ_IDLE);
         // a data set offered mid-frame is dropped; flag it one cycle later, for every cycle the request stays up
         txOverrun_r <= dataSetReady && (seq_r != aifs_pkg::SEQ_IDLE);
      end
   end

   assign txValid = txValid_r;
   assign txFirst = txFirst_r;
   assign txLast = txLast_r;
   assign txKind = txKind_r;
   assign txChannel = txChannel_r;
   assign txWord = txWord_r;
   assign txBusy = txBusy_r;
   assign txOverrun = txOverrun_r;

endmodule

`default_nettype wire

// >>> verif/aifs_fault_status_assertions.sv
// concurrent property checker for the fault and status block ports
`timescale 1ns/10ps
`default_nettype none

module aifs_fault_status_assertions #(
   parameter int NUM_CH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // watched inputs
   input wire logic [1:0] wiringMode,
   input wire logic ownerCommLost,
   input wire logic [NUM_CH-1:0] chanCalibrating,
   input wire logic [NUM_CH-1:0] chanCalError,
   input wire logic [NUM_CH*aifs_pkg::ALARM_W-1:0] chanAlarms,
   // watched outputs
   input wire logic [aifs_pkg::WORD_W-1:0] moduleFaultSummary,
   input wire logic [aifs_pkg::WORD_W-1:0] channelFaultBits,
   input wire logic [NUM_CH*aifs_pkg::STAT_W-1:0] channelStatusFlags,
   input wire logic txValid,
   input wire logic txFirst,
   input wire logic [aifs_pkg::KIND_W-1:0] txKind
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////
   // spare wiring code 3 falls back to the single-ended pattern
   wire logic [15:0] calMask = (wiringMode == 2'h1) ? 16'h000F : (wiringMode == 2'h2) ? 16'h0003 : 16'h00FF;
   wire logic anyCal = |chanCalibrating;
   wire logic anyCalErr = |chanCalError;
   wire logic [4:0] alarm0 = chanAlarms[4:0];

   sequence s_head;
      txValid && txFirst && txKind == 2'h0;
   endsequence
   sequence s_body;
      txValid && txKind == 2'h1 ##1 txValid && txKind == 2'h2 ##1 txValid && txKind == 2'h3;
   endsequence

   ////////////////////////////////////////
   property p_groupFault; moduleFaultSummary[15] == (channelFaultBits != 16'h0000); endproperty
   a_groupFault: assert property (p_groupFault) else $error("group fault bit disagrees with fault word");
   property p_spareBits; moduleFaultSummary[14:11] == 4'h0; endproperty
   a_spareBits: assert property (p_spareBits) else $error("spare summary bits not zero");
   property p_linkLost; ownerCommLost |=> channelFaultBits == 16'hFFFF; endproperty
   a_linkLost: assert property (p_linkLost) else $error("fault word not all ones on lost link");
   property p_calMask; !ownerCommLost && anyCal |=> channelFaultBits == $past(calMask); endproperty
   a_calMask: assert property (p_calMask) else $error("calibration pattern wrong for wiring mode");
   property p_calBusy; $past(reset_n) |-> moduleFaultSummary[10] == $past(anyCal); endproperty
   a_calBusy: assert property (p_calBusy) else $error("calibrating summary bit wrong");
   // the error flag runs through the status stage first, hence two cycles
   property p_calErr; $past(reset_n, 2) && $past(reset_n) |-> moduleFaultSummary[9] == $past(anyCalErr, 2); endproperty
   a_calErr: assert property (p_calErr) else $error("calibration error summary bit wrong");
   // alarms cross the status flop and then the output flop, hence two cycles
   property p_alarmPass;
      $past(reset_n, 2) && $past(reset_n) |-> channelStatusFlags[4:0] == $past(alarm0, 2);
   endproperty
   a_alarmPass: assert property (p_alarmPass) else $error("channel 0 alarm flags misplaced");
   // every position outside the active set must stay clear, not only the upper byte
   property p_inactiveZero;
      !ownerCommLost && !anyCal |=> (channelFaultBits & ~$past(calMask)) == 16'h0000;
   endproperty
   a_inactiveZero: assert property (p_inactiveZero) else $error("inactive fault bits set in normal operation");
   property p_frameHead; s_head |=> s_body; endproperty
   a_frameHead: assert property (p_frameHead) else $error("frame header order broken");
endmodule

`default_nettype wire

// >>> verif/aifs_frame_receiver.sv
// passive model of the controller that takes the multicast word stream
`timescale 1ns/10ps
`default_nettype none

module aifs_frame_receiver (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // multicast word stream
   input wire logic txValid,
   input wire logic txFirst,
   input wire logic txLast,
   input wire logic [aifs_pkg::KIND_W-1:0] txKind,
   input wire logic [aifs_pkg::WORD_W-1:0] txWord,
   // captured frame, kind above word in each slot
   output logic [0:17][17:0] rxFrame,
   output logic [4:0] rxLen,
   output logic rxGap
);
   logic [4:0] slot_r;
   logic inFrame_r;
   wire logic [4:0] slot = txFirst ? 5'h00 : slot_r;

   // the length is only known at the last word, so it is stored then
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         slot_r <= 5'h00;
         inFrame_r <= 1'b0;
         rxLen <= 5'h00;
         rxGap <= 1'b0;
      end
      else if (txValid)
      begin
         rxFrame[slot] <= {txKind, txWord};
         slot_r <= slot + 5'h01;
         inFrame_r <= !txLast;
         if (txLast)
            rxLen <= slot + 5'h01;
      end
      else if (inFrame_r)
         rxGap <= 1'b1;
   end
endmodule

`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the fault and status block
`timescale 1ns/10ps
`default_nettype none

module testbench;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] wiringMode = 2'h0;
   logic commMethod = 1'b0;
   logic ownerCommLost = 1'b0;
   logic [7:0] chanCalibrating = 8'h00;
   logic [7:0] chanCalError = 8'h00;
   logic [39:0] chanAlarms = 40'h0;
   logic [127:0] chanSample = {8{16'h8000}};
   logic dataSetReady = 1'b0;
   logic [15:0] moduleFaultSummary;
   logic [15:0] channelFaultBits;
   logic [63:0] channelStatusFlags;
   logic txValid, txFirst, txLast, txBusy, txOverrun;
   logic [1:0] txKind;
   logic [3:0] txChannel;
   logic [15:0] txWord;
   logic [0:17][17:0] rxFrame;
   logic [4:0] rxLen;
   logic rxGap;
   logic [15:0] rangeExp [3] = '{16'h0009, 16'h0009, 16'h0001};
   logic [15:0] calExp [4] = '{16'h00FF, 16'h000F, 16'h0003, 16'h00FF};
   logic [17:0] frameExp [6] = '{18'h08000, 18'h10001, 18'h20000, 18'h30040, 18'h21234, 18'h30000};
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;

   always #2.5 ref_clk = ~ref_clk;

   aifs_fault_status aifs_fault_status_i (.ref_clk, .reset_n, .wiringMode, .commMethod, .ownerCommLost,
      .chanCalibrating, .chanCalError, .chanAlarms, .chanSample, .dataSetReady, .moduleFaultSummary,
      .channelFaultBits, .channelStatusFlags, .txValid, .txFirst, .txLast, .txKind, .txChannel, .txWord,
      .txBusy, .txOverrun);
   aifs_frame_receiver aifs_frame_receiver_i (.ref_clk, .reset_n, .txValid, .txFirst, .txLast, .txKind,
      .txWord, .rxFrame, .rxLen, .rxGap);

   ////////////////////////////////////////
   task automatic summarize;
      if (bad_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [17:0] expv, input logic [17:0] got);
      n_tests++;
      if (got !== expv)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, expv, got);
      end
   endtask

   // sampling 1 ns after the edge keeps checks clear of the flops' updates
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // hold above one keeps the request up into the frame, which must be dropped
   task automatic send_frame(input logic [4:0] expLen, input int hold);
      int t;
      t = 0;
      @(posedge ref_clk);
      dataSetReady <= 1'b1;
      repeat (hold) @(posedge ref_clk);
      dataSetReady <= 1'b0;
      #1;
      check("busy at start", 18'h00001, 18'(txBusy));
      check("overrun flag", 18'(hold > 1), 18'(txOverrun));
      while (txLast !== 1'b1 && t < 40)
      begin
         @(posedge ref_clk);
         #1;
         t++;
      end
      check("last channel", 18'((expLen - 5'h02) / 5'h02 - 5'h01), 18'(txChannel));
      check("busy at last", 18'h00000, 18'(txBusy));
      tick(1);
      check("frame length", 18'(expLen), 18'(rxLen));
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         summarize();
      end
   end

   ////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      chanSample[15:0] <= 16'h0000;
      chanSample[63:48] <= 16'hFFFF;
      chanSample[95:80] <= 16'h0001;
      chanSample[111:96] <= 16'hFFFE;
      for (int m = 0; m < 3; m++)
      begin
         @(posedge ref_clk);
         wiringMode <= 2'(m);
         tick(3);
         check("range fault word", 18'(rangeExp[m]), 18'(channelFaultBits));
         check("group fault", 18'h08000, 18'(moduleFaultSummary));
         check("ch0 status", 18'h00040, 18'(channelStatusFlags[7:0]));
         check("ch3 status", 18'h00020, 18'(channelStatusFlags[31:24]));
         check("ch5 status", 18'h00000, 18'(channelStatusFlags[47:40]));
      end
      @(posedge ref_clk);
      chanSample <= {8{16'h8000}};
      chanAlarms <= {{7{5'h1F}}, 5'h16};
      tick(3);
      check("alarm status", 18'h00016, 18'(channelStatusFlags[7:0]));
      check("alarm fault word", 18'h00000, 18'(channelFaultBits));
      check("alarm summary", 18'h00000, 18'(moduleFaultSummary));
      @(posedge ref_clk);
      chanAlarms <= 40'h0;
      chanCalError <= 8'h10;
      tick(3);
      check("cal error status", 18'h00080, 18'(channelStatusFlags[39:32]));
      check("cal error summary", 18'h00200, 18'(moduleFaultSummary));
      @(posedge ref_clk);
      chanCalError <= 8'h00;
      chanCalibrating <= 8'h02;
      for (int m = 0; m < 4; m++)
      begin
         @(posedge ref_clk);
         wiringMode <= 2'(m);
         tick(3);
         check("calibrating fault word", 18'(calExp[m]), 18'(channelFaultBits));
         check("calibrating summary", 18'h08400, 18'(moduleFaultSummary));
      end
      @(posedge ref_clk);
      wiringMode <= 2'h2;
      ownerCommLost <= 1'b1;
      tick(3);
      check("link lost fault word", 18'h0FFFF, 18'(channelFaultBits));
      @(posedge ref_clk);
      ownerCommLost <= 1'b0;
      chanCalibrating <= 8'h00;
      chanSample[15:0] <= 16'h0000;
      chanSample[31:16] <= 16'h1234;
      tick(3);
      send_frame(5'h06, 1);
      for (int i = 0; i < 6; i++)
         check("frame word", frameExp[i], rxFrame[i]);
      @(posedge ref_clk);
      commMethod <= 1'b1;
      send_frame(5'h12, 3);
      check("last status kind", 18'h00003, 18'(rxFrame[17][17:16]));
      check("frame gap", 18'h00000, 18'(rxGap));
      summarize();
   end
endmodule

bind aifs_fault_status aifs_fault_status_assertions #(.NUM_CH(NUM_CH)) aifs_fault_status_assertions_i (
   .ref_clk, .reset_n, .wiringMode, .ownerCommLost, .chanCalibrating, .chanCalError, .chanAlarms,
   .moduleFaultSummary, .channelFaultBits, .channelStatusFlags, .txValid, .txFirst, .txKind);

`default_nettype wire
